// >>> logic/bmc_pkg.sv
// package for the basic mode control register bank
// assumes a 50 MHz system clock and a 5-bit management register address
package bmc_pkg;

	localparam int          CLK_MHZ          = 50;
	localparam int          ADDR_W           = 5;
	localparam int          DATA_W           = 16;
	localparam int          REG_COUNT        = 32;
	localparam logic [4:0]  OFFS_BASIC_CTRL  = 5'h00;
	localparam logic [4:0]  OFFS_LOOP_BYPASS = 5'h18;

	localparam int          BIT_RESET        = 15;
	localparam int          BIT_LOOPBACK     = 14;
	localparam int          BIT_SPEED        = 13;
	localparam int          BIT_NEG_ENABLE   = 12;
	localparam int          BIT_RESERVED     = 11;
	localparam int          BIT_DUPLEX       = 8;
	localparam int          BIT_BYP_LOOP_LO  = 8;
	localparam int          BIT_BYP_LOOP_HI  = 9;

	localparam logic [15:0] BASIC_CTRL_RESET = 16'h3100;
	localparam logic [15:0] LOOP_BYPASS_RESET = 16'h0000;

	// software reset sequence length
	localparam int          SOFT_RESET_US    = 2;
	localparam int          SOFT_RESET_CYC   = SOFT_RESET_US * CLK_MHZ;
	// loopback dead time at 100 Mb/s, a least time
	localparam int          DEAD_TIME_US     = 550;
	localparam int          DEAD_TIME_CYC    = DEAD_TIME_US * CLK_MHZ;

	typedef struct packed {
		logic       write;
		logic       read;
		logic [4:0] addr;
		logic [15:0] wdata;
	} mgmt_req_t;

	typedef struct packed {
		logic speed_100;
		logic full_duplex;
		logic neg_enable;
		logic neg_start;
		logic loopback;
		logic [1:0] bypass_loop;
		logic dead_time;
	} link_cfg_t;

	typedef struct packed {
		logic neg_zero;
		logic neg_one;
	} strap_t;

endpackage : bmc_pkg

// >>> logic/strap_sampler.sv
// samples the negotiation straps through two flip-flops and latches them
// assumes a load pulse from the reset sequencer on the same clock
`timescale 1ns/1ps
module strap_sampler
	import bmc_pkg::*;
(
	input  wire logic   clk_sys,
	input  wire logic   reset,
	input  wire strap_t strap_pin,
	input  wire logic   load,
	output strap_t      strap
);

	strap_t meta;
	strap_t sync;

	// no reset here: the pins are through both stages when reset lifts,
	// so the boot load never catches a cleared stage
	always_ff @(posedge clk_sys) begin
		meta <= strap_pin;
		sync <= meta;
	end

	// latched only on load, so straps are caught after reset release
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			strap <= '0;
		else if (load)
			strap <= sync;
	end

endmodule : strap_sampler

// >>> logic/cycle_timer.sv
// down counter that holds busy for a fixed number of cycles after start
// assumes start is a one-cycle pulse on clk_sys
`timescale 1ns/1ps
module cycle_timer #(
	parameter int COUNT = 100
) (
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic start,
	output logic      busy
);

	localparam int W = $clog2(COUNT + 1);
	localparam logic [W-1:0] LOAD = W'(COUNT);

	logic [W-1:0] left;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			left <= '0;
		else if (start)
			left <= LOAD;
		else if (left != '0)
			left <= left - W'(1);
	end

	assign busy = (left != '0);

endmodule : cycle_timer

// >>> logic/basic_mode_control_reg.sv
// basic mode control register bank of a 10/100 physical layer device
// assumes a management frame engine that presents single-cycle
// read and write strobes on clk_sys; strap pins are asynchronous
// Summary of operation
// - writing one to bit 15 returns all control and status registers to defaults
// - software reset also resamples the configuration straps
// - reset bit reads one while the sequence runs, zero when done
// - loopback bit 14 routes transmit data back to receive at both speeds
// - loopback at 100 Mb/s starts a 550 us dead time with no traffic
// - loopback bit overrides loopback bits 8 and 9 of register 18h
// - speed bit 13 chooses 100 or 10 Mb/s, followed under negotiation too
// - latched negotiation straps influence speed and outrank enable bit
// - negotiation enable bit 12 makes duplex bit ignored (full duplex); speed bit still used
// - with negotiation off, speed from bit 13 and duplex from bit 8
// - enabling negotiation after strapped-off start needs zero then one
// - reserved bit 11 written zero, read value ignored
// - defaults follow self-clearing, latching, permanent and strap keys
// - duplex bit 8 selects full or half duplex when negotiation off
// - each register is a 16-bit word, up to 32 per device
`timescale 1ns/1ps
module basic_mode_control_reg
	import bmc_pkg::*;
#(
	parameter int DEAD_CYCLES  = DEAD_TIME_CYC,
	parameter int RESET_CYCLES = SOFT_RESET_CYC
) (
	input  wire logic      clk_sys,
	input  wire logic      reset,
	input  wire mgmt_req_t req,
	input  wire strap_t    strap_pin,
	output logic [15:0]    rdata,
	output logic           rvalid,
	output link_cfg_t      cfg,
	output logic           soft_reset_busy
);

	function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
		hit = (a == o);
	endfunction : hit

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_RESET = 2'b01,
		ST_LOAD  = 2'b10,
		ST_APPLY = 2'b11
	} seq_t;

	seq_t   state;
	seq_t   next_state;
	strap_t strap;
	logic   timer_start;
	logic   timer_busy;
	logic   strap_load;
	logic   defaults;
	logic   soft_req;
	logic   dead_start;
	logic   dead_busy;
	logic   boot;

	logic        loopback;
	logic        speed;
	logic        neg_enable;
	logic        duplex;
	logic        neg_armed;
	logic        neg_zeroed;
	logic        neg_start;
	logic [15:0] loop_bypass;

	logic wr_ctrl;
	logic wr_byp;

	assign wr_ctrl  = req.write && hit(req.addr, OFFS_BASIC_CTRL);
	assign wr_byp   = req.write && hit(req.addr, OFFS_LOOP_BYPASS);
	assign soft_req = wr_ctrl && req.wdata[BIT_RESET] && (state == ST_IDLE);

	// boot pulse after hardware reset release catches the straps
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			boot <= 1'b1;
		else
			boot <= 1'b0;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	always_comb begin
		next_state  = state;
		timer_start = 1'b0;
		case (state)
			ST_IDLE: begin
				if (soft_req) begin
					next_state  = ST_RESET;
					timer_start = 1'b1;
				end
			end
			ST_RESET: begin
				if (!timer_busy)
					next_state = ST_LOAD;
			end
			ST_LOAD:
				next_state = ST_APPLY;
			// defaults land here, so writes stay refused and bit 15 set
			ST_APPLY:
				next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	assign strap_load      = boot || (state == ST_LOAD);
	// defaults applied a cycle after the straps land so they are seen
	assign soft_reset_busy = (state != ST_IDLE);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			defaults <= 1'b0;
		else
			defaults <= strap_load;
	end

	cycle_timer #(
		.COUNT (RESET_CYCLES)
	) reset_timer (
		.clk_sys (clk_sys),
		.reset   (reset),
		.start   (timer_start),
		.busy    (timer_busy)
	);

	strap_sampler straps (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.strap_pin (strap_pin),
		.load      (strap_load),
		.strap     (strap)
	);

	// straps: both low forces negotiation off at 10 Mb/s, otherwise
	// neg_zero alone picks speed with negotiation off when neg_one is low
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			speed      <= BASIC_CTRL_RESET[BIT_SPEED];
			neg_enable <= BASIC_CTRL_RESET[BIT_NEG_ENABLE];
			duplex     <= BASIC_CTRL_RESET[BIT_DUPLEX];
		end else if (defaults) begin
			speed      <= strap.neg_zero || strap.neg_one;
			neg_enable <= strap.neg_one;
			duplex     <= BASIC_CTRL_RESET[BIT_DUPLEX];
		end else if (wr_ctrl && state == ST_IDLE) begin
			speed      <= req.wdata[BIT_SPEED];
			neg_enable <= req.wdata[BIT_NEG_ENABLE];
			duplex     <= req.wdata[BIT_DUPLEX];
		end
	end

	// zero-then-one arming; a strapped-on enable is armed by the defaults after reset
	// a one counts only after a zero was written since the last defaults
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			neg_armed  <= 1'b0;
			neg_zeroed <= 1'b0;
			neg_start  <= 1'b0;
		end else begin
			neg_start <= 1'b0;
			if (defaults) begin
				neg_armed  <= strap.neg_one;
				neg_zeroed <= 1'b0;
			end else if (wr_ctrl && state == ST_IDLE) begin
				if (!req.wdata[BIT_NEG_ENABLE]) begin
					neg_armed  <= 1'b0;
					neg_zeroed <= 1'b1;
				end else if (neg_zeroed) begin
					neg_armed  <= 1'b1;
					neg_zeroed <= 1'b0;
					neg_start  <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			loopback <= BASIC_CTRL_RESET[BIT_LOOPBACK];
		else if (defaults)
			loopback <= 1'b0;
		else if (wr_ctrl && state == ST_IDLE)
			loopback <= req.wdata[BIT_LOOPBACK];
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			loop_bypass <= LOOP_BYPASS_RESET;
		else if (defaults)
			loop_bypass <= LOOP_BYPASS_RESET;
		else if (wr_byp && state == ST_IDLE)
			loop_bypass <= req.wdata;
	end

	// dead time only when loopback is newly set while running 100 Mb/s
	assign dead_start = wr_ctrl && (state == ST_IDLE) && !loopback
		&& req.wdata[BIT_LOOPBACK] && cfg.speed_100;

	cycle_timer #(
		.COUNT (DEAD_CYCLES)
	) dead_timer (
		.clk_sys (clk_sys),
		.reset   (reset),
		.start   (dead_start),
		.busy    (dead_busy)
	);

	always_comb begin
		cfg             = '0;
		cfg.neg_enable  = neg_enable && neg_armed;
		// duplex follows bit 8 only with negotiation off; speed always follows bit 13
		cfg.speed_100   = speed;
		cfg.full_duplex = neg_enable ? 1'b1 : duplex;
		cfg.neg_start   = neg_start;
		cfg.loopback    = loopback;
		cfg.bypass_loop = loopback ? 2'b00
			: loop_bypass[BIT_BYP_LOOP_HI:BIT_BYP_LOOP_LO];
		cfg.dead_time   = dead_busy;
	end

	// reserved bit reads zero; software must ignore it anyway
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rdata  <= '0;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.read;
			rdata  <= '0;
			if (req.read && hit(req.addr, OFFS_BASIC_CTRL)) begin
				rdata[BIT_RESET]      <= soft_reset_busy || soft_req;
				rdata[BIT_LOOPBACK]   <= loopback;
				rdata[BIT_SPEED]      <= speed;
				rdata[BIT_NEG_ENABLE] <= neg_enable;
				rdata[BIT_RESERVED]   <= 1'b0;
				rdata[BIT_DUPLEX]     <= duplex;
			end else if (req.read && hit(req.addr, OFFS_LOOP_BYPASS))
				rdata <= loop_bypass;
		end
	end

	reset_bit_holds_a: assert property (@(posedge clk_sys) disable iff (reset)
		soft_req |=> soft_reset_busy [*2])
		else $error("reset bit dropped early");

	defaults_after_seq_a: assert property (@(posedge clk_sys)
		disable iff (reset)
		state == ST_LOAD |=> ##1 (!loopback && loop_bypass == 16'h0000))
		else $error("defaults not restored");

	loop_override_a: assert property (@(posedge clk_sys) disable iff (reset)
		loopback |-> cfg.bypass_loop == 2'b00)
		else $error("bypass loopback not overridden");

	dead_time_a: assert property (@(posedge clk_sys) disable iff (reset)
		dead_start |=> dead_busy [*8])
		else $error("dead time too short");

	neg_arm_a: assert property (@(posedge clk_sys) disable iff (reset)
		(wr_ctrl && state == ST_IDLE && !req.wdata[BIT_NEG_ENABLE])
		|=> !cfg.neg_enable)
		else $error("negotiation not disarmed");

	duplex_sel_a: assert property (@(posedge clk_sys) disable iff (reset)
		!neg_enable |-> cfg.full_duplex == duplex)
		else $error("duplex not taken from bit");

	reserved_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(rvalid) && $past(req.addr) == OFFS_BASIC_CTRL
		|-> !rdata[BIT_RESERVED])
		else $error("reserved bit reads one");

	strap_reload_a: assert property (@(posedge clk_sys) disable iff (reset)
		state == ST_LOAD |=> defaults ##1 neg_enable == strap.neg_one)
		else $error("straps not reapplied");

endmodule : basic_mode_control_reg

// >>> bench/mgmt_station.sv
// management station model issuing register reads and writes
// assumes the register bank takes req on the rising edge of clk_sys
`timescale 1ns/1ps
module mgmt_station
	import bmc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic [15:0] rdata,
	input  wire logic        rvalid,
	output mgmt_req_t        req
);
	initial req = '0;

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		req <= '{1'b1, 1'b0, a, d & 16'hf7ff};
		@(posedge clk_sys);
		// released data is inverted so stale values never look valid
		req <= '{1'b0, 1'b0, a, ~d};
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [15:0] d,
			output logic v);
		@(posedge clk_sys);
		req <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk_sys);
		req <= '{1'b0, 1'b0, a, 16'hffff};
		#1;
		d = rdata & 16'hf7ff;
		v = rvalid;
	endtask : rd
endmodule : mgmt_station

// >>> bench/basic_mode_control_reg_tb.sv
// self-checking bench for the basic mode control register bank
// assumes short dead time and soft reset counts set by parameter
`timescale 1ns/1ps
module basic_mode_control_reg_tb;
	import bmc_pkg::*;
	localparam int DEAD = 20;
	localparam int RST  = 10;
	logic        clk_sys;
	logic        reset;
	strap_t      strap_pin;
	mgmt_req_t   req;
	logic [15:0] rdata;
	logic        rvalid;
	link_cfg_t   cfg;
	logic        busy;
	int          num_errors;
	int          n_checks;

	basic_mode_control_reg #(.DEAD_CYCLES(DEAD), .RESET_CYCLES(RST)) DUT (
		.clk_sys(clk_sys), .reset(reset), .req(req), .strap_pin(strap_pin),
		.rdata(rdata), .rvalid(rvalid), .cfg(cfg),
		.soft_reset_busy(busy));
	mgmt_station st (.clk_sys(clk_sys), .rdata(rdata), .rvalid(rvalid),
		.req(req));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic check(input string what, input logic [15:0] got,
			input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic give_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	task automatic settle;
		@(posedge clk_sys);
		#1;
	endtask : settle

	task automatic rdc(input logic [4:0] a, input logic [15:0] exp,
			input string what);
		logic [15:0] d;
		logic        v;
		st.rd(a, d, v);
		check("rvalid", {15'h0000, v}, 16'h0001);
		check(what, d, exp);
	endtask : rdc

	task automatic t_defaults;
		rdc(5'h00, 16'h3100, "ctrl default");
		check("neg_enable", {15'h0000, cfg.neg_enable}, 16'h0001);
		check("duplex", {15'h0000, cfg.full_duplex}, 16'h0001);
		rdc(5'h05, 16'h0000, "unmapped");
	endtask : t_defaults

	task automatic t_forced;
		st.wr(5'h00, 16'h2100);
		settle();
		check("speed", {15'h0000, cfg.speed_100}, 16'h0001);
		check("duplex", {15'h0000, cfg.full_duplex}, 16'h0001);
		check("neg off", {15'h0000, cfg.neg_enable}, 16'h0000);
		st.wr(5'h00, 16'h0000);
		settle();
		check("speed10", {15'h0000, cfg.speed_100}, 16'h0000);
		check("half", {15'h0000, cfg.full_duplex}, 16'h0000);
		st.wr(5'h00, 16'h1000);
		settle();
		check("neg on", {15'h0000, cfg.neg_enable}, 16'h0001);
		check("dup ignored", {15'h0000, cfg.full_duplex}, 16'h0001);
	endtask : t_forced

	task automatic t_loop;
		st.wr(5'h18, 16'h0300);
		settle();
		check("bypass", {14'h0000, cfg.bypass_loop}, 16'h0003);
		// loopback has to land on a link already running at 100 Mb/s
		st.wr(5'h00, 16'h2000);
		st.wr(5'h00, 16'h6000);
		settle();
		check("loopback", {15'h0000, cfg.loopback}, 16'h0001);
		check("bypass ovr", {14'h0000, cfg.bypass_loop}, 16'h0000);
		check("dead", {15'h0000, cfg.dead_time}, 16'h0001);
		repeat (DEAD + 5) @(posedge clk_sys);
		#1;
		check("dead end", {15'h0000, cfg.dead_time}, 16'h0000);
	endtask : t_loop

	task automatic t_soft;
		logic [15:0] d;
		logic        v;
		@(posedge clk_sys);
		strap_pin <= '{1'b1, 1'b0};
		repeat (25000) @(posedge clk_sys);
		st.wr(5'h00, 16'h8000);
		st.rd(5'h00, d, v);
		check("reset bit", {15'h0000, d[15]}, 16'h0001);
		// a write while busy must be dropped
		st.wr(5'h18, 16'h0100);
		rdc(5'h18, 16'h0300, "write refused");
		for (int i = 0; i < RST + 20 && busy !== 1'b0; i++)
			settle();
		check("busy", {15'h0000, busy}, 16'h0000);
		settle();
		rdc(5'h00, 16'h2100, "ctrl after soft");
		check("strap", {15'h0000, cfg.neg_enable}, 16'h0000);
		rdc(5'h18, 16'h0000, "bypass after soft");
		st.wr(5'h00, 16'h3100);
		#1;
		check("no start", {15'h0000, cfg.neg_start}, 16'h0000);
		settle();
		check("not armed", {15'h0000, cfg.neg_enable}, 16'h0000);
		rdc(5'h00, 16'h3100, "enable as control");
		st.wr(5'h00, 16'h2100);
		st.wr(5'h00, 16'h3100);
		#1;
		check("neg start", {15'h0000, cfg.neg_start}, 16'h0001);
		settle();
		check("armed", {15'h0000, cfg.neg_enable}, 16'h0001);
	endtask : t_soft

	initial begin
		num_errors = 0;
		n_checks   = 0;
		reset      = 1'b1;
		strap_pin  = '{1'b1, 1'b1};
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (3) @(posedge clk_sys);
		t_defaults();
		t_forced();
		t_loop();
		t_soft();
		give_verdict();
	end

	initial begin
		repeat (40000) @(posedge clk_sys);
		num_errors++;
		give_verdict();
	end
endmodule : basic_mode_control_reg_tb
